/* data_pin_pkg.sv */
package data_pin_pkg;

    // Register byte offsets
    localparam logic [7:0] SYSTEM_CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] STRAP_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] PIN_INPUT_OFFSET = 8'h08;

    // System control register layout
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;
    localparam logic [2:0] MODE_RESET = 3'h7;

    // Data pin modes
    localparam logic [2:0] MODE_MEM = 3'h0;
    localparam logic [2:0] MODE_FLAGS = 3'h3;
    localparam logic [2:0] MODE_ACQ = 3'h5;
    localparam logic [2:0] MODE_OFF = 3'h7;

    // Boot select codes
    localparam logic [2:0] BOOT_CODE_SPI_SLAVE = 3'h0;
    localparam logic [2:0] BOOT_CODE_SPI_MASTER = 3'h1;
    localparam logic [2:0] BOOT_CODE_FLASH8 = 3'h2;
    localparam logic [2:0] BOOT_CODE_LINK0 = 3'h4;

    // Core ratio codes and their ratios
    localparam logic [1:0] RATIO_CODE_6 = 2'h0;
    localparam logic [1:0] RATIO_CODE_32 = 2'h1;
    localparam logic [1:0] RATIO_CODE_16 = 2'h2;
    localparam logic [5:0] RATIO_6 = 6'h06;
    localparam logic [5:0] RATIO_16 = 6'h10;
    localparam logic [5:0] RATIO_32 = 6'h20;
    localparam logic [5:0] RATIO_NONE = 6'h00;

    // Strap status register layout
    localparam int ST_BOOT_LSB = 0;
    localparam int ST_RATIO_LSB = 3;
    localparam int ST_BOOT_RSVD = 8;
    localparam int ST_RATIO_RSVD = 9;
    localparam int ST_CAPTURED = 10;
    localparam int ST_RUNNING = 11;
    localparam int ST_RATIO_VAL_LSB = 16;

    // Timing counts in clock cycles
    localparam int LOCK_CYCLES = 4096;
    localparam int STRAP_SETTLE = 2;

    typedef enum logic [2:0] {
        BOOT_SPI_SLAVE,
        BOOT_SPI_MASTER,
        BOOT_FLASH8,
        BOOT_LINK0,
        BOOT_RESERVED
    } boot_mode_e;

    // Shared pins: 24 address and 8 data
    typedef struct packed {
        logic [23:0] addr;
        logic [7:0] data;
    } pin_bus_s;

endpackage

/* data_pin_and_strap_decode.sv */
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module data_pin_and_strap_decode #(
    parameter int LOCK_CYCLES = data_pin_pkg::LOCK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Shared pins
    input wire data_pin_pkg::pin_bus_s pin_in,
    output data_pin_pkg::pin_bus_s pin_out,
    output data_pin_pkg::pin_bus_s pin_oe,
    // Straps
    input wire logic [2:0] boot_select_straps,
    input wire logic [1:0] core_ratio_straps,
    // Memory interface unit
    input wire logic [23:0] mem_addr,
    input wire logic [7:0] mem_data_out,
    input wire logic mem_data_oe,
    output logic [7:0] mem_data_in,
    // Flag and PWM units
    input wire logic [15:0] flag_pwm_out,
    input wire logic [15:0] flag_pwm_oe,
    output logic [15:0] flag_pwm_in,
    input wire logic [15:0] flag_out,
    input wire logic [15:0] flag_oe,
    output logic [15:0] flag_in,
    // Acquisition unit
    output logic [15:0] acq_data_in,
    // Start-up status
    output logic [2:0] data_pin_mode,
    output data_pin_pkg::boot_mode_e boot_mode,
    output logic [5:0] core_ratio,
    output logic straps_captured,
    output logic core_run
);

    localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);

    logic [2:0] mode_reg;
    data_pin_pkg::pin_bus_s sync1_reg;
    data_pin_pkg::pin_bus_s sync2_reg;
    logic [2:0] boot_sync1_reg;
    logic [2:0] boot_sync2_reg;
    logic [1:0] ratio_sync1_reg;
    logic [1:0] ratio_sync2_reg;
    logic [2:0] boot_code_reg;
    logic [1:0] ratio_code_reg;
    logic [LOCK_W-1:0] lock_count_reg;
    logic setup_phase;
    logic access_done;
    logic addr_hit;
    logic [31:0] read_value;
    data_pin_pkg::boot_mode_e boot_next;
    logic [5:0] ratio_next;
    logic capture_now;

    // All checks run on the core clock and stand down during reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Modes not listed as usable leave every pin undriven
    function automatic logic mode_usable(input logic [2:0] m);
        mode_usable = (m == data_pin_pkg::MODE_MEM) || (m == data_pin_pkg::MODE_FLAGS)
            || (m == data_pin_pkg::MODE_ACQ);
    endfunction

    function automatic data_pin_pkg::boot_mode_e boot_decode(input logic [2:0] c);
        case (c)
            data_pin_pkg::BOOT_CODE_SPI_SLAVE: boot_decode = data_pin_pkg::BOOT_SPI_SLAVE;
            data_pin_pkg::BOOT_CODE_SPI_MASTER: boot_decode = data_pin_pkg::BOOT_SPI_MASTER;
            data_pin_pkg::BOOT_CODE_FLASH8: boot_decode = data_pin_pkg::BOOT_FLASH8;
            data_pin_pkg::BOOT_CODE_LINK0: boot_decode = data_pin_pkg::BOOT_LINK0;
            default: boot_decode = data_pin_pkg::BOOT_RESERVED;
        endcase
    endfunction

    function automatic logic [5:0] ratio_decode(input logic [1:0] c);
        case (c)
            data_pin_pkg::RATIO_CODE_6: ratio_decode = data_pin_pkg::RATIO_6;
            data_pin_pkg::RATIO_CODE_32: ratio_decode = data_pin_pkg::RATIO_32;
            data_pin_pkg::RATIO_CODE_16: ratio_decode = data_pin_pkg::RATIO_16;
            default: ratio_decode = data_pin_pkg::RATIO_NONE;
        endcase
    endfunction

    // Pin and strap synchronisers, two flops before any use
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            boot_sync1_reg <= 3'h0;
            boot_sync2_reg <= 3'h0;
            ratio_sync1_reg <= 2'h0;
            ratio_sync2_reg <= 2'h0;
        end
        else
        begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            boot_sync1_reg <= boot_select_straps;
            boot_sync2_reg <= boot_sync1_reg;
            ratio_sync1_reg <= core_ratio_straps;
            ratio_sync2_reg <= ratio_sync1_reg;
        end
    end

    // Start-up counter; capture waits until the synchronisers hold post-reset levels
    assign capture_now = (lock_count_reg == LOCK_W'(data_pin_pkg::STRAP_SETTLE)) && !straps_captured;
    assign boot_next = boot_decode(boot_sync2_reg);
    assign ratio_next = ratio_decode(ratio_sync2_reg);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            lock_count_reg <= '0;
            core_run <= 1'b0;
        end
        else if (lock_count_reg != LOCK_W'(LOCK_CYCLES))
        begin
            lock_count_reg <= lock_count_reg + LOCK_W'(1);
            core_run <= (lock_count_reg == LOCK_W'(LOCK_CYCLES - 1));
        end
    end

    // Straps are taken once; later pin changes are ignored
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            straps_captured <= 1'b0;
            boot_code_reg <= 3'h0;
            ratio_code_reg <= 2'h0;
            boot_mode <= data_pin_pkg::BOOT_SPI_SLAVE;
            core_ratio <= data_pin_pkg::RATIO_NONE;
        end
        else if (capture_now)
        begin
            straps_captured <= 1'b1;
            boot_code_reg <= boot_sync2_reg;
            ratio_code_reg <= ratio_sync2_reg;
            boot_mode <= boot_next;
            core_ratio <= ratio_next;
        end
    end

    // APB: setup cycle registers the answer, access phase completes in one cycle
    assign setup_phase = psel && !penable && !pready;
    assign access_done = psel && penable && pready;
    assign addr_hit = (paddr == data_pin_pkg::SYSTEM_CONTROL_OFFSET) || (paddr == data_pin_pkg::STRAP_STATUS_OFFSET)
        || (paddr == data_pin_pkg::PIN_INPUT_OFFSET);

    always_comb
    begin
        read_value = 32'h0000_0000;
        case (paddr)
            data_pin_pkg::SYSTEM_CONTROL_OFFSET:
                read_value[data_pin_pkg::MODE_LSB +: data_pin_pkg::MODE_W] = mode_reg;
            data_pin_pkg::STRAP_STATUS_OFFSET:
            begin
                read_value[data_pin_pkg::ST_BOOT_LSB +: 3] = boot_code_reg;
                read_value[data_pin_pkg::ST_RATIO_LSB +: 2] = ratio_code_reg;
                read_value[data_pin_pkg::ST_BOOT_RSVD] = straps_captured
                    && (boot_mode == data_pin_pkg::BOOT_RESERVED);
                read_value[data_pin_pkg::ST_RATIO_RSVD] = straps_captured
                    && (core_ratio == data_pin_pkg::RATIO_NONE);
                read_value[data_pin_pkg::ST_CAPTURED] = straps_captured;
                read_value[data_pin_pkg::ST_RUNNING] = core_run;
                read_value[data_pin_pkg::ST_RATIO_VAL_LSB +: 6] = core_ratio;
            end
            data_pin_pkg::PIN_INPUT_OFFSET: read_value = {sync2_reg.data, sync2_reg.addr};
            default: read_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup_phase;
            pslverr <= setup_phase && !addr_hit;
            prdata <= (setup_phase && !pwrite) ? read_value : 32'h0000_0000;
        end
    end

    // Mode field; a flash boot selects the memory bus so the loader can fetch
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            mode_reg <= data_pin_pkg::MODE_RESET;
        else if (capture_now && boot_next == data_pin_pkg::BOOT_FLASH8)
            mode_reg <= data_pin_pkg::MODE_MEM;
        else if (access_done && pwrite && paddr == data_pin_pkg::SYSTEM_CONTROL_OFFSET)
            mode_reg <= pwdata[data_pin_pkg::MODE_LSB +: data_pin_pkg::MODE_W];
    end

    assign data_pin_mode = mode_reg;

    // Pin drive, registered so pins never glitch during a mode change
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pin_out <= '0;
            pin_oe <= '0;
        end
        else
        begin
            pin_out <= '0;
            pin_oe <= '0;
            case (mode_reg)
                data_pin_pkg::MODE_MEM:
                begin
                    pin_out.addr <= mem_addr;
                    pin_oe.addr <= 24'hFF_FFFF;
                    pin_out.data <= mem_data_out;
                    pin_oe.data <= {8{mem_data_oe}};
                end
                data_pin_pkg::MODE_FLAGS:
                begin
                    pin_out.addr[23:8] <= flag_pwm_out;
                    pin_oe.addr[23:8] <= flag_pwm_oe;
                    pin_out.addr[7:0] <= flag_out[7:0];
                    pin_oe.addr[7:0] <= flag_oe[7:0];
                    pin_out.data <= flag_out[15:8];
                    pin_oe.data <= flag_oe[15:8];
                end
                data_pin_pkg::MODE_ACQ:
                begin
                    pin_out.addr[7:0] <= flag_out[7:0];
                    pin_oe.addr[7:0] <= flag_oe[7:0]; // Upper pins stay input
                end
                default:
                begin
                    pin_out <= '0;
                    pin_oe <= '0;
                end
            endcase
        end
    end

    // Inputs returned to the units; a unit not selected sees zeros
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            mem_data_in <= 8'h00;
            flag_pwm_in <= 16'h0000;
            flag_in <= 16'h0000;
            acq_data_in <= 16'h0000;
        end
        else
        begin
            mem_data_in <= (mode_reg == data_pin_pkg::MODE_MEM) ? sync2_reg.data : 8'h00;
            flag_pwm_in <= (mode_reg == data_pin_pkg::MODE_FLAGS) ? sync2_reg.addr[23:8] : 16'h0000;
            if (mode_reg == data_pin_pkg::MODE_FLAGS)
                flag_in <= {sync2_reg.data, sync2_reg.addr[7:0]};
            else if (mode_reg == data_pin_pkg::MODE_ACQ)
                flag_in <= {8'h00, sync2_reg.addr[7:0]};
            else
                flag_in <= 16'h0000;
            acq_data_in <= (mode_reg == data_pin_pkg::MODE_ACQ) ? sync2_reg.addr[23:8] : 16'h0000;
        end
    end

    // Checks next to the logic
    AST_MEM_MODE: assert property ((mode_reg == data_pin_pkg::MODE_MEM) |=> pin_oe.addr == 24'hFF_FFFF)
        else $error("memory mode did not drive all address pins");
    AST_ACQ_INPUT: assert property ((mode_reg == data_pin_pkg::MODE_ACQ) |=>
        pin_oe.addr[23:8] == 16'h0000 && pin_oe.data == 8'h00)
        else $error("acquisition pins driven");
    AST_FLAG_ROUTE: assert property ((mode_reg == data_pin_pkg::MODE_FLAGS) |=>
        pin_out.addr[23:8] == $past(flag_pwm_out) && pin_oe.data == $past(flag_oe[15:8]))
        else $error("flag routing wrong in mode 011");
    AST_FLAG8: assert property ((mode_reg == data_pin_pkg::MODE_ACQ) |=>
        pin_oe.addr[7:0] == $past(flag_oe[7:0]) && acq_data_in == $past(sync2_reg.addr[23:8]))
        else $error("mode 101 routing wrong");
    AST_TRISTATE: assert property (!mode_usable(mode_reg) |=> pin_oe == '0)
        else $error("pins driven in off or reserved mode");
    AST_STRAP_HOLD: assert property (straps_captured && $past(straps_captured) |->
        $stable(boot_mode) && $stable(core_ratio))
        else $error("strap values changed after capture");
    AST_RATIO: assert property (straps_captured |->
        (ratio_code_reg == 2'h0) == (core_ratio == 6'h06) && (ratio_code_reg == 2'h1) == (core_ratio == 6'h20))
        else $error("ratio decode wrong");
    AST_BOOT: assert property (straps_captured |->
        (boot_code_reg == 3'h1) == (boot_mode == data_pin_pkg::BOOT_SPI_MASTER)
        && (boot_code_reg == 3'h4) == (boot_mode == data_pin_pkg::BOOT_LINK0))
        else $error("boot decode wrong");
    AST_FLASH_BOOT: assert property ($rose(straps_captured) && boot_mode == data_pin_pkg::BOOT_FLASH8
        |-> mode_reg == data_pin_pkg::MODE_MEM)
        else $error("flash boot did not select memory pins");
    AST_LOCK: assert property ($rose(core_run) |->
        lock_count_reg == LOCK_W'(LOCK_CYCLES) && $past(lock_count_reg) == LOCK_W'(LOCK_CYCLES - 1))
        else $error("core ran before lock count");
    AST_APB_ANSWER: assert property (setup_phase |=> pready ##1 !pready)
        else $error("APB answer not in one cycle");

    COV_FLAGS: cover property (mode_reg == data_pin_pkg::MODE_FLAGS ##1 mode_reg == data_pin_pkg::MODE_FLAGS);
    COV_ACQ: cover property (mode_reg == data_pin_pkg::MODE_ACQ ##1 mode_reg == data_pin_pkg::MODE_ACQ);
    COV_RUN: cover property ($rose(core_run));
    COV_FLASH: cover property ($rose(straps_captured) && boot_mode == data_pin_pkg::BOOT_FLASH8);

endmodule

/* pin_far_side_model.sv */
`timescale 1ns/100ps
module pin_far_side_model (
    // Pins seen from the board
    input wire data_pin_pkg::pin_bus_s pin_out,
    input wire data_pin_pkg::pin_bus_s pin_oe,
    output data_pin_pkg::pin_bus_s pin_in,
    // Levels the memory or host drives
    input wire logic [31:0] ext_level,
    input wire logic [2:0] board_boot,
    input wire logic [1:0] board_ratio,
    output logic [2:0] boot_select_straps,
    output logic [1:0] core_ratio_straps
);
    // Host drives every pin the device leaves free, so no line floats to a guess
    assign pin_in = data_pin_pkg::pin_bus_s'((pin_out & pin_oe) | (ext_level & ~pin_oe));
    // Straps are board levels, already valid when reset asserts
    assign boot_select_straps = board_boot;
    assign core_ratio_straps = board_ratio;
endmodule

/* test_data_pin_and_strap_decode.sv */
`timescale 1ns/100ps
module test_data_pin_and_strap_decode;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, mem_data_oe, straps_captured, core_run;
    logic [7:0] paddr, mem_data_out, mem_data_in;
    logic [31:0] pwdata, prdata, ext_level;
    data_pin_pkg::pin_bus_s pin_in, pin_out, pin_oe;
    logic [2:0] boot_select_straps, board_boot, data_pin_mode;
    logic [1:0] core_ratio_straps, board_ratio;
    logic [23:0] mem_addr;
    logic [15:0] flag_pwm_out, flag_pwm_oe, flag_pwm_in, flag_out, flag_oe, flag_in, acq_data_in;
    data_pin_pkg::boot_mode_e boot_mode;
    logic [5:0] core_ratio;
    int err_total, compares;

    // Short lock count keeps each reset run brief
    data_pin_and_strap_decode #(.LOCK_CYCLES(8)) u_data_pin_and_strap_decode (.clk(clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .boot_select_straps(boot_select_straps), .core_ratio_straps(core_ratio_straps), .mem_addr(mem_addr),
        .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in),
        .flag_pwm_out(flag_pwm_out), .flag_pwm_oe(flag_pwm_oe), .flag_pwm_in(flag_pwm_in), .flag_out(flag_out),
        .flag_oe(flag_oe), .flag_in(flag_in), .acq_data_in(acq_data_in), .data_pin_mode(data_pin_mode),
        .boot_mode(boot_mode), .core_ratio(core_ratio), .straps_captured(straps_captured), .core_run(core_run));

    pin_far_side_model u_pin_far_side_model (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
        .ext_level(ext_level), .board_boot(board_boot), .board_ratio(board_ratio),
        .boot_select_straps(boot_select_straps), .core_ratio_straps(core_ratio_straps));

    // Core clock, 10 ns period
    always #5 clk = ~clk;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task complete_run;
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One APB transfer; an idle cycle follows so psel is never set twice in one step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic e);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        // No cycle count is assumed; only the watchdog ends a wait that never sees pready
        do
            @(posedge clk);
        while (pready !== 1'h1);
        rd = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask

    // Reset with given straps, then check capture, hold and lock wait
    task strap_run(input logic [2:0] b, input logic [1:0] r);
        logic [31:0] rd;
        logic e;
        logic [5:0] er;
        data_pin_pkg::boot_mode_e eb;
        case (b)
            3'h0: eb = data_pin_pkg::BOOT_SPI_SLAVE;
            3'h1: eb = data_pin_pkg::BOOT_SPI_MASTER;
            3'h2: eb = data_pin_pkg::BOOT_FLASH8;
            3'h4: eb = data_pin_pkg::BOOT_LINK0;
            default: eb = data_pin_pkg::BOOT_RESERVED;
        endcase
        er = r == 2'h0 ? 6'h06 : r == 2'h1 ? 6'h20 : r == 2'h2 ? 6'h10 : 6'h00;
        board_boot <= b;
        board_ratio <= r;
        @(posedge clk);
        reset <= 1'h1;
        repeat (4) @(posedge clk);
        reset <= 1'h0;
        repeat (3) @(posedge clk);
        chk(straps_captured, 32'h0);
        @(posedge clk);
        chk(straps_captured, 32'h1);
        chk(boot_mode, eb);
        chk(core_ratio, er);
        chk(data_pin_mode, b == 3'h2 ? data_pin_pkg::MODE_MEM : data_pin_pkg::MODE_OFF);
        board_boot <= ~b;
        board_ratio <= ~r;
        repeat (4) @(posedge clk);
        chk(core_run, 32'h0);
        @(posedge clk);
        chk(core_run, 32'h1);
        chk(boot_mode, eb);
        apb(1'h0, data_pin_pkg::STRAP_STATUS_OFFSET, 32'h0, rd, e);
        chk(rd, {10'h0, er, 4'h0, 2'h3, r == 2'h3, eb == data_pin_pkg::BOOT_RESERVED, 3'h0, r, b});
    endtask

    // Main sequence
    initial
    begin
        logic [31:0] rd, eo, xo, lvl;
        logic e;
        clk = 1'h0;
        reset = 1'h1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {board_boot, board_ratio, mem_data_oe} = '0;
        ext_level = 32'h3CA5C35A;
        mem_addr = 24'h5A3C96;
        mem_data_out = 8'hC3;
        flag_pwm_out = 16'h9A6B;
        flag_pwm_oe = 16'hF0F0;
        flag_out = 16'h3C5A;
        flag_oe = 16'h0FF0;
        for (int i = 0; i < 8; i++)
            strap_run(i[2:0], i[1:0]);
        for (int k = 0; k < 2; k++)
        begin
            for (int m = 0; m < 8; m++)
            begin
                mem_data_oe <= k[0];
                flag_oe <= k[0] ? 16'hF00F : 16'h0FF0;
                ext_level <= k[0] ? 32'hA5C35A3C : 32'h3CA5C35A;
                apb(1'h1, data_pin_pkg::SYSTEM_CONTROL_OFFSET, 32'hFFFFFFF8 | 32'(m), rd, e);
                repeat (5) @(posedge clk);
                apb(1'h0, data_pin_pkg::SYSTEM_CONTROL_OFFSET, 32'h0, rd, e);
                chk(rd, 32'(m));
                chk(data_pin_mode, 32'(m));
                case (m)
                    0: {eo, xo} = {24'hFFFFFF, {8{mem_data_oe}}, mem_addr, mem_data_out};
                    3: {eo, xo} = {flag_pwm_oe, flag_oe[7:0], flag_oe[15:8], flag_pwm_out, flag_out[7:0], flag_out[15:8]};
                    5: {eo, xo} = {16'h0, flag_oe[7:0], 8'h0, 16'h0, flag_out[7:0], 8'h0};
                    default: {eo, xo} = 64'h0;
                endcase
                lvl = (xo & eo) | (ext_level & ~eo);
                chk(pin_oe, eo);
                chk(pin_out & eo, xo & eo);
                chk(mem_data_in, m == 0 ? lvl[7:0] : 8'h0);
                chk(flag_pwm_in, m == 3 ? lvl[31:16] : 16'h0);
                chk(flag_in, m == 3 ? {lvl[7:0], lvl[15:8]} : m == 5 ? {8'h0, lvl[15:8]} : 16'h0);
                chk(acq_data_in, m == 5 ? lvl[31:16] : 16'h0);
                apb(1'h0, data_pin_pkg::PIN_INPUT_OFFSET, 32'h0, rd, e);
                chk(rd, {lvl[7:0], lvl[31:8]});
            end
        end
        // Unmapped address: error flagged, read zero, write leaves the mode alone
        apb(1'h0, 8'h0C, 32'h0, rd, e);
        chk(rd, 32'h0);
        chk(e, 1'h1);
        apb(1'h1, 8'h0C, 32'h5, rd, e);
        chk(e, 1'h1);
        apb(1'h0, data_pin_pkg::SYSTEM_CONTROL_OFFSET, 32'h0, rd, e);
        chk(rd, 32'(data_pin_pkg::MODE_OFF));
        complete_run;
    end

    // Watchdog at 1000 cycles, well past the roughly 400 the run needs
    initial
    begin
        #10000;
        err_total++;
        complete_run;
    end
endmodule
